// ### rtc_pkg.sv
package rtc_pkg;
  // command codes
  localparam logic [7:0] OP_DESEL_REC      = 8'h19;
  localparam logic [7:0] OP_DESEL_UNREC    = 8'h1a;
  localparam logic [7:0] OP_DESEL_MISMATCH = 8'h05;
  localparam logic [7:0] OP_SLOT_ADVANCE   = 8'h08;
  localparam logic [7:0] OP_NEXT_ROUND     = 8'h09;
  localparam logic [7:0] OP_RESEND         = 8'h15;
  localparam logic [7:0] OP_RESET          = 8'h0a;
  localparam logic [7:0] OP_READ           = 8'h0c;
  localparam logic [7:0] OP_VAR_FETCH      = 8'h51;
  localparam logic [7:0] OP_CHECKED_READ   = 8'h1d;
  localparam logic [7:0] OP_WRITE          = 8'h1b;
  // one-byte answers
  localparam logic [7:0] RESP_ACK          = 8'h00;
  localparam logic [7:0] RESP_ERROR        = 8'hff;
  // register byte offsets
  localparam logic [7:0] ADDR_CMD          = 8'h00;
  localparam logic [7:0] ADDR_ARGS         = 8'h04;
  localparam logic [7:0] ADDR_SERIAL_LO    = 8'h08;
  localparam logic [7:0] ADDR_SERIAL_HI    = 8'h0c;
  localparam logic [7:0] ADDR_DATA_LO      = 8'h10;
  localparam logic [7:0] ADDR_DATA_HI      = 8'h14;
  localparam logic [7:0] ADDR_STATUS       = 8'h18;
  localparam logic [7:0] ADDR_REPLY_CTRL   = 8'h1c;
  localparam logic [7:0] ADDR_REPLY_LO     = 8'h20;
  localparam logic [7:0] ADDR_REPLY_HI     = 8'h24;
  localparam logic [7:0] ADDR_POP          = 8'h28;
  localparam logic [7:0] ADDR_LOCKS        = 8'h2c;
  // field positions
  localparam int         CMD_CRC_ERR_BIT   = 8;
  localparam int         ST_RECOG_BIT      = 2;
  localparam int         ST_WOK_BIT        = 3;
  localparam int         ST_LOCKABLE_BIT   = 4;
  localparam int         ST_BUSY_BIT       = 5;
  localparam int         ST_SLOT_POS       = 8;
  localparam int         ST_LOCK_ADDR_POS  = 16;
  localparam int         RC_VALID_BIT      = 3;
  localparam int         RC_LEN_POS        = 4;
  localparam int         RC_LEFT_POS       = 16;
  // counts
  localparam logic [7:0] SLOT_ZERO         = 8'h00;
  localparam logic [7:0] SLOT_MAX          = 8'hff;
  localparam logic [8:0] READ_BYTES        = 9'h008;
  localparam logic [8:0] CHECK_BYTES       = 9'h004;
  localparam logic [1:0] WOK_EXPIRE        = 2'h1;
  typedef enum logic [1:0] {TAG_READY, TAG_CANDIDATE, TAG_ACCESS} rtc_tag_state_t;
  typedef enum logic [2:0] {RPL_NONE, RPL_SERIAL, RPL_DATA, RPL_ACK, RPL_ERROR} rtc_reply_t;
endpackage : rtc_pkg

// ### rtc_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rtc_mem_if #(parameter int AW = 5);
  logic [AW-1:0]     rd_addr;
  logic [63:0]       rd_win;
  logic [3:0]        lock_win;
  logic [AW-1:0]     ptr_addr;
  logic [7:0]        ptr_byte;
  logic              wr_en;
  logic [3:0]        wr_mask;
  logic [31:0]       wr_data;
  logic              lock_wr;
  logic [(1<<AW)-1:0] lock_wdata;
  logic [(1<<AW)-1:0] locks;
  modport host  (output rd_addr, ptr_addr, wr_en, wr_mask, wr_data, lock_wr, lock_wdata,
                 input  rd_win, lock_win, ptr_byte, locks);
  modport store (input  rd_addr, ptr_addr, wr_en, wr_mask, wr_data, lock_wr, lock_wdata,
                 output rd_win, lock_win, ptr_byte, locks);
endinterface : rtc_mem_if
`default_nettype wire

// ### rtc_mem.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_mem
  import rtc_pkg::*;
#(
  parameter int AW = 5
) (
  // clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // engine side
  rtc_mem_if.store   mif
);
  localparam int DEPTH = 1 << AW;

  logic [7:0]       mem [DEPTH];
  logic [DEPTH-1:0] locks;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] base, input int off);
    wrap = base + AW'(off);
  endfunction : wrap

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_win
      assign mif.rd_win[8*gi +: 8] = mem[wrap(mif.rd_addr, gi)];
    end
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign mif.lock_win[gi] = locks[wrap(mif.rd_addr, gi)];
    end
  endgenerate

  // one process owns the array; lane i programmed when mask bit 3-i is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (mif.wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (mif.wr_mask[3-i]) begin
          mem[wrap(mif.rd_addr, i)] <= mif.wr_data[8*i +: 8];
        end
      end
    end
  end

  assign mif.ptr_byte = mem[mif.ptr_addr];
  assign mif.locks    = locks;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locks <= '0;
    end else if (mif.lock_wr) begin
      locks <= mif.lock_wdata;
    end
  end
endmodule : rtc_mem
`default_nettype wire

// ### rtc_rng.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_rng #(
  parameter logic [7:0] SEED = 8'h5a
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // random bit
  output logic     bit_o
);
  logic [7:0] lfsr;

  // x^8 + x^6 + x^5 + x^4 + 1, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  assign bit_o = lfsr[0];
endmodule : rtc_rng
`default_nettype wire

// ### rtc_engine.sv
// Contract
// - deselect-if-recognised: recognised candidate goes ready, silent
// - deselect-if-recognised: unrecognised candidate zeroes slot, replies serial, stays candidate
// - no reply condition met means nothing is transmitted
// - deselect-if-unrecognised: unrecognised candidate goes ready, silent
// - deselect-if-unrecognised: recognised candidate zeroes slot, replies serial, stays candidate
// - deselect-on-mismatch: pattern differs from memory, candidate goes ready silently
// - deselect-on-mismatch: pattern matches, zero slot, reply serial, stay candidate
// - slot-advance: counter nonzero or random one increments, saturating at ff
// - after slot-advance or next-round, zero counter replies serial
// - next-round decrements a nonzero counter
// - resend replies serial when counter is zero
// - reset command: ready state, clear recognised, silent
// - matching read: access state, return eight bytes from address
// - matching read or variable read arms lock permit for address
// - matching variable read: access state, return length plus one bytes
// - checked read with match and write-success: access, return four bytes
// - matching write: access state, error answer if any of four bytes locked
// - all four unlocked: acknowledge, then program memory
// - only mask-enabled lanes programmed, B7 is address plus zero
// - write-success set on completed write, cleared otherwise
// - lock permit drops on any other command or erroneous frame
// - write-success cleared by start of second command after a write
`timescale 1ns/10ps
`default_nettype none
module rtc_engine
  import rtc_pkg::*;
#(
  parameter logic [63:0] SERIAL      = 64'h0123456789abcdef, // arbitrary value
  parameter int          AW          = 5,
  parameter int          PROG_CYCLES = 4
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // status
  output logic             busy,
  output logic             reply_valid
);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_EXEC, SEQ_PROG} rtc_seq_t;
  localparam int PCW = $clog2(PROG_CYCLES + 1);

  rtc_mem_if #(.AW(AW)) mif ();

  rtc_mem #(.AW(AW)) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (mif)
  );

  logic rng_bit;

  rtc_rng u_rng (
    .pclk    (pclk),
    .presetn (presetn),
    .bit_o   (rng_bit)
  );

  // command fields
  logic [7:0]     cmd_op;
  logic           cmd_crc_err;
  logic [7:0]     cmd_addr;
  logic [7:0]     cmd_arg;
  logic [63:0]    cmd_serial;
  logic [63:0]    cmd_data;
  // tag state
  rtc_tag_state_t tag_state;
  logic           recognised;
  logic [7:0]     slot_count;
  logic           write_ok;
  logic [1:0]     wok_age;
  logic           lockable;
  logic [7:0]     lock_addr;
  rtc_seq_t       seq;
  logic [PCW-1:0] prog_cnt;
  // reply
  rtc_reply_t     reply_kind;
  logic [8:0]     reply_len;
  logic [63:0]    reply_word;
  logic [7:0]     rd_ptr;
  logic [8:0]     rd_left;
  logic [31:0]    lock_table;

  // bus decode
  logic apb_setup;
  logic apb_done;
  logic apb_wr;
  logic apb_rd;
  logic mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      ADDR_CMD, ADDR_ARGS, ADDR_SERIAL_LO, ADDR_SERIAL_HI, ADDR_DATA_LO, ADDR_DATA_HI,
      ADDR_STATUS, ADDR_REPLY_CTRL, ADDR_REPLY_LO, ADDR_REPLY_HI, ADDR_POP,
      ADDR_LOCKS: is_mapped = 1'b1;
      default:    is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign apb_setup = psel && !penable;
  assign apb_done  = psel && penable && pready;
  assign mapped    = is_mapped(paddr);
  assign apb_wr    = apb_done && pwrite && mapped;
  assign apb_rd    = apb_done && !pwrite && mapped;

  // execution decisions
  logic           exec;
  logic           cand;
  logic           serial_hit;
  logic           wok_live;
  logic           prog_done;
  rtc_tag_state_t dec_state;
  logic           dec_recog;
  logic [7:0]     dec_slot;
  rtc_reply_t     dec_reply;
  logic [8:0]     dec_len;
  logic           dec_lockable;
  logic           dec_write;

  assign exec       = (seq == SEQ_EXEC) && !cmd_crc_err;
  assign cand       = (tag_state == TAG_CANDIDATE);
  assign serial_hit = (cmd_serial == SERIAL);
  assign wok_live   = write_ok && (wok_age != WOK_EXPIRE);
  assign prog_done  = (seq == SEQ_PROG) && (prog_cnt == PCW'(PROG_CYCLES));

  always_comb begin
    dec_state    = tag_state;
    dec_recog    = recognised;
    dec_slot     = slot_count;
    dec_reply    = RPL_NONE;
    dec_len      = '0;
    dec_lockable = 1'b0;
    dec_write    = 1'b0;
    case (cmd_op)
      OP_DESEL_REC: begin
        if (cand && recognised) begin
          dec_state = TAG_READY;
        end else if (cand) begin
          dec_slot  = SLOT_ZERO;
          dec_reply = RPL_SERIAL;
        end
      end
      OP_DESEL_UNREC: begin
        if (cand && !recognised) begin
          dec_state = TAG_READY;
        end else if (cand) begin
          dec_slot  = SLOT_ZERO;
          dec_reply = RPL_SERIAL;
        end
      end
      OP_DESEL_MISMATCH: begin
        if (cand && (mif.rd_win != cmd_data)) begin
          dec_state = TAG_READY;
        end else if (cand) begin
          dec_slot  = SLOT_ZERO;
          dec_reply = RPL_SERIAL;
        end
      end
      OP_SLOT_ADVANCE: begin
        if (cand) begin
          if ((slot_count != SLOT_ZERO) || rng_bit) begin
            dec_slot = (slot_count == SLOT_MAX) ? SLOT_MAX : slot_count + 8'h01;
          end
          if (dec_slot == SLOT_ZERO) begin
            dec_reply = RPL_SERIAL;
          end
        end
      end
      OP_NEXT_ROUND: begin
        if (cand) begin
          if (slot_count != SLOT_ZERO) begin
            dec_slot = slot_count - 8'h01;
          end
          if (dec_slot == SLOT_ZERO) begin
            dec_reply = RPL_SERIAL;
          end
        end
      end
      OP_RESEND: begin
        if (cand && (slot_count == SLOT_ZERO)) begin
          dec_reply = RPL_SERIAL;
        end
      end
      OP_RESET: begin
        dec_state = TAG_READY;
        dec_recog = 1'b0;
      end
      OP_READ: begin
        if (serial_hit) begin
          dec_state    = TAG_ACCESS;
          dec_recog    = 1'b1;
          dec_reply    = RPL_DATA;
          dec_len      = READ_BYTES;
          dec_lockable = 1'b1;
        end
      end
      OP_VAR_FETCH: begin
        if (serial_hit) begin
          dec_state    = TAG_ACCESS;
          dec_recog    = 1'b1;
          dec_reply    = RPL_DATA;
          dec_len      = {1'b0, cmd_arg} + 9'h001;
          dec_lockable = 1'b1;
        end
      end
      OP_CHECKED_READ: begin
        if (serial_hit && wok_live) begin
          dec_state = TAG_ACCESS;
          dec_recog = 1'b1;
          dec_reply = RPL_DATA;
          dec_len   = CHECK_BYTES;
        end
      end
      OP_WRITE: begin
        if (serial_hit) begin
          dec_state = TAG_ACCESS;
          dec_recog = 1'b1;
          if (|mif.lock_win) begin
            dec_reply = RPL_ERROR;
          end else begin
            dec_reply = RPL_ACK;
            dec_write = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // memory hookup: write lanes follow bits 7..4 of the mask byte
  assign mif.rd_addr    = cmd_addr[AW-1:0];
  assign mif.ptr_addr   = rd_ptr[AW-1:0];
  assign mif.wr_en      = prog_done;
  assign mif.wr_mask    = cmd_arg[7:4];
  assign mif.wr_data    = cmd_data[31:0];
  assign mif.lock_wr    = apb_wr && (paddr == ADDR_LOCKS);
  assign mif.lock_wdata = pwdata[(1<<AW)-1:0];
  assign lock_table     = 32'(mif.locks);

  // sequencer: a cmd write while seq is not SEQ_IDLE is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq      <= SEQ_IDLE;
      prog_cnt <= '0;
    end else begin
      case (seq)
        SEQ_IDLE: begin
          if (apb_wr && (paddr == ADDR_CMD)) begin
            seq <= SEQ_EXEC;
          end
        end
        SEQ_EXEC: begin
          prog_cnt <= '0;
          seq      <= (exec && dec_write) ? SEQ_PROG : SEQ_IDLE;
        end
        SEQ_PROG: begin
          prog_cnt <= prog_cnt + PCW'(1);
          if (prog_done) begin
            seq <= SEQ_IDLE;
          end
        end
        default: begin
          seq <= SEQ_IDLE;
        end
      endcase
    end
  end

  // command field registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_op      <= 8'h00;
      cmd_crc_err <= 1'b0;
      cmd_addr    <= 8'h00;
      cmd_arg     <= 8'h00;
      cmd_serial  <= 64'h0;
      cmd_data    <= 64'h0;
    end else if (apb_wr && (seq == SEQ_IDLE)) begin
      case (paddr)
        ADDR_CMD: begin
          cmd_op      <= pwdata[7:0];
          cmd_crc_err <= pwdata[CMD_CRC_ERR_BIT];
        end
        ADDR_ARGS: begin
          cmd_addr <= pwdata[7:0];
          cmd_arg  <= pwdata[15:8];
        end
        ADDR_SERIAL_LO: cmd_serial[31:0]  <= pwdata;
        ADDR_SERIAL_HI: cmd_serial[63:32] <= pwdata;
        ADDR_DATA_LO:   cmd_data[31:0]    <= pwdata;
        ADDR_DATA_HI:   cmd_data[63:32]   <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // tag state and recognised flag; status write stands in for selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_state  <= TAG_READY;
      recognised <= 1'b0;
    end else if (exec) begin
      tag_state  <= dec_state;
      recognised <= dec_recog;
    end else if (apb_wr && (paddr == ADDR_STATUS) && (seq == SEQ_IDLE)) begin
      tag_state  <= rtc_tag_state_t'(pwdata[1:0]);
      recognised <= pwdata[ST_RECOG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_count <= SLOT_ZERO;
    end else if (exec) begin
      slot_count <= dec_slot;
    end
  end

  // write-success flag and its command age
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_ok <= 1'b0;
      wok_age  <= WOK_EXPIRE;
    end else if (prog_done) begin
      write_ok <= 1'b1;
      wok_age  <= 2'h0;
    end else if (exec) begin
      if (dec_reply == RPL_ERROR) begin
        write_ok <= 1'b0;
      end else if (!wok_live) begin
        write_ok <= 1'b0;
      end
      if (wok_age != WOK_EXPIRE) begin
        wok_age <= wok_age + 2'h1;
      end
    end
  end

  // lock permit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lockable  <= 1'b0;
      lock_addr <= 8'h00;
    end else if (seq == SEQ_EXEC) begin
      lockable <= exec && dec_lockable;
      if (exec && dec_lockable) begin
        lock_addr <= cmd_addr;
      end
    end
  end

  // reply buffer; data bytes drain one at a time from the command address through the pop register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_kind  <= RPL_NONE;
      reply_valid <= 1'b0;
      reply_len   <= '0;
      reply_word  <= 64'h0;
      rd_ptr      <= 8'h00;
      rd_left     <= '0;
    end else if (seq == SEQ_EXEC) begin
      reply_kind  <= exec ? dec_reply : RPL_NONE;
      reply_valid <= exec && (dec_reply != RPL_NONE);
      reply_len   <= dec_len;
      rd_ptr      <= cmd_addr;
      rd_left     <= exec ? dec_len : 9'h000;
      case (dec_reply)
        RPL_SERIAL: reply_word <= SERIAL;
        RPL_DATA:   reply_word <= mif.rd_win;
        RPL_ACK:    reply_word <= {56'h0, RESP_ACK};
        RPL_ERROR:  reply_word <= {56'h0, RESP_ERROR};
        default:    reply_word <= 64'h0;
      endcase
    end else if (apb_rd && (paddr == ADDR_POP) && (rd_left != 9'h000)) begin
      rd_ptr  <= rd_ptr + 8'h01;
      rd_left <= rd_left - 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (seq != SEQ_IDLE) || (apb_wr && (paddr == ADDR_CMD));
    end
  end

  // apb answer: one wait-free access phase, data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !mapped;
      prdata  <= 32'h0;
      if (apb_setup && !pwrite) begin
        case (paddr)
          ADDR_CMD:       prdata <= {23'h0, cmd_crc_err, cmd_op};
          ADDR_ARGS:      prdata <= {16'h0, cmd_arg, cmd_addr};
          ADDR_SERIAL_LO: prdata <= cmd_serial[31:0];
          ADDR_SERIAL_HI: prdata <= cmd_serial[63:32];
          ADDR_DATA_LO:   prdata <= cmd_data[31:0];
          ADDR_DATA_HI:   prdata <= cmd_data[63:32];
          ADDR_STATUS: begin
            prdata[1:0]                   <= tag_state;
            prdata[ST_RECOG_BIT]          <= recognised;
            prdata[ST_WOK_BIT]            <= write_ok;
            prdata[ST_LOCKABLE_BIT]       <= lockable;
            prdata[ST_BUSY_BIT]           <= busy;
            prdata[ST_SLOT_POS +: 8]      <= slot_count;
            prdata[ST_LOCK_ADDR_POS +: 8] <= lock_addr;
          end
          ADDR_REPLY_CTRL: begin
            prdata[2:0]              <= reply_kind;
            prdata[RC_VALID_BIT]     <= reply_valid;
            prdata[RC_LEN_POS +: 9]  <= reply_len;
            prdata[RC_LEFT_POS +: 9] <= rd_left;
          end
          ADDR_REPLY_LO:  prdata <= reply_word[31:0];
          ADDR_REPLY_HI:  prdata <= reply_word[63:32];
          ADDR_POP:       prdata <= (rd_left != 9'h000) ? {24'h0, mif.ptr_byte} : 32'h0;
          ADDR_LOCKS:     prdata <= lock_table;
          default:        prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule : rtc_engine
`default_nettype wire

// ### rtc_engine_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_engine_sva
  import rtc_pkg::*;
#(
  parameter int PROG_CYCLES = 4
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status
  input wire logic        busy,
  input wire logic        reply_valid
);
  localparam int WMAX = PROG_CYCLES + 4;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go = psel && penable && pready && pwrite && paddr == ADDR_CMD && !busy;
  wire acc = go && !pwdata[8];
  property p_ready; pready |-> psel && penable && !$past(penable); endproperty
  a_ready: assert property (p_ready) else $error("pready outside first access cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_unm; pready && paddr > ADDR_LOCKS |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not flagged");
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access cycle");
  property p_rv; $changed(reply_valid) |-> busy && $past(busy) && !$past(busy, 2); endproperty
  a_rv: assert property (p_rv) else $error("reply changed without a command");
  property p_crc; go && pwdata[8] |-> ##2 !reply_valid; endproperty
  a_crc: assert property (p_crc) else $error("bad frame gave a reply");
  property p_rst; acc && pwdata[7:0] == OP_RESET |-> ##2 !reply_valid; endproperty
  a_rst: assert property (p_rst) else $error("reset command replied");
  property p_cmd; acc && pwdata[7:0] != OP_WRITE |=> busy ##1 busy ##1 !busy; endproperty
  a_cmd: assert property (p_cmd) else $error("command busy length wrong");
  property p_wr; acc && pwdata[7:0] == OP_WRITE |=> busy ##[1:WMAX] !busy; endproperty
  a_wr: assert property (p_wr) else $error("write never finished");
  c_wr: cover property (acc && pwdata[7:0] == OP_WRITE);
  c_unm: cover property (pslverr);
  c_rv: cover property ($rose(reply_valid));
endmodule : rtc_engine_sva
bind rtc_engine rtc_engine_sva #(.PROG_CYCLES(PROG_CYCLES)) sva_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy), .reply_valid(reply_valid));
`default_nettype wire

// ### rtc_reader.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_reader
  import rtc_pkg::*;
(
  // answer side
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  input  wire logic        busy,
  // request side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // one frame, then hold off until the tag is done with it
  task automatic send(input logic [8:0] c);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, ADDR_CMD, {23'h0, c}, q, e);
    @(posedge pclk);
    do @(posedge pclk); while (busy !== 1'b0);
  endtask : send
endmodule : rtc_reader
`default_nettype wire

// ### rtc_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_engine_tb;
  import rtc_pkg::*;
  localparam logic [63:0] SER = 64'h0123456789abcdef;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, reply_valid, e;
  logic [7:0]  paddr, a;
  logic [31:0] pwdata, prdata, q, d, w;
  logic [31:0] rs = 32'h17;
  logic [7:0]  mem [32];
  int          err_count = 0, check_count = 0, cyc = 0, stt = 0, rec = 0, wok = 0, slot = 0;
  rtc_engine #(.PROG_CYCLES(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .reply_valid(reply_valid));
  rtc_reader rdr_u (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .busy(busy),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  function automatic logic [31:0] mw(input logic [4:0] b);
    return {mem[b + 5'd3], mem[b + 5'd2], mem[b + 5'd1], mem[b]};
  endfunction : mw
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] ad);
    rdr_u.xfer(1'b0, ad, 32'h0, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    rdr_u.xfer(1'b1, ad, v, q, e);
  endtask : wr
  task automatic look(input logic [3:0] k, input logic [31:0] lo, input logic [31:0] m);
    rd(ADDR_STATUS);
    chk("status", {slot[7:0], 4'h0, wok[0], rec[0], stt[1:0]}, q[15:0] & 16'hff0f);
    rd(ADDR_REPLY_CTRL);
    chk("reply", k, q[3:0]);
    chk("flags", {k[3], 1'b0, 1'b0}, {reply_valid, busy, e});
    rd(ADDR_REPLY_LO);
    if (k[3]) chk("reply_lo", lo & m, q & m);
  endtask : look
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    look(4'h0, 0, 0);
    rd(8'h30);
    chk("slverr", 1, e);
    wr(ADDR_SERIAL_LO, SER[31:0]);
    wr(ADDR_SERIAL_HI, SER[63:32]);
    for (int i = 0; i < 6; i++) begin
      rec = i % 2;
      wr(ADDR_STATUS, {29'h0, i[0], 2'h1});
      wr(ADDR_DATA_LO, {31'h0, i[0]});
      rdr_u.send(i < 2 ? OP_DESEL_REC : i < 4 ? OP_DESEL_UNREC : OP_DESEL_MISMATCH);
      stt = (i < 4 ? i[1] ^ i[0] : i[0]) ? 0 : 1;
      look(stt ? 4'h9 : 4'h0, SER[31:0], '1);
    end
    wr(ADDR_STATUS, 32'h1);
    stt = 1;
    rec = 0;
    for (int n = 0; n < 820; n++) begin
      rdr_u.send(n < 300 ? OP_SLOT_ADVANCE : n[0] ? OP_RESEND : OP_NEXT_ROUND);
      rd(ADDR_STATUS);
      if (n < 300) slot = slot ? (slot == 255 ? 255 : slot + 1) : (q[15:8] == 8'h01 ? 1 : 0);
      else if (!n[0] && slot) slot--;
      look(slot ? 4'h0 : 4'h9, SER[31:0], '1);
    end
    wr(ADDR_STATUS, 32'h5);
    rec = 1;
    rdr_u.send({1'b1, OP_RESET});
    look(4'h0, 0, 0);
    rdr_u.send({1'b0, OP_RESET});
    stt = 0;
    rec = 0;
    look(4'h0, 0, 0);
    for (int k = 0; k < 3; k++) begin
      d = xs();
      a = {3'h0, d[4:2], 2'h0};
      w = xs();
      if (k == 2) wr(ADDR_LOCKS, 32'h1 << (a + 8'h1));
      wr(ADDR_ARGS, {16'h0, d[31:24], a});
      wr(ADDR_DATA_LO, w);
      rdr_u.send(OP_WRITE);
      stt = 2;
      rec = 1;
      wok = k < 2;
      for (int b = 0; b < 4; b++) if (k < 2 && d[31 - b]) mem[5'(a + b)] = w[8*b +: 8];
      look(k < 2 ? 4'hb : 4'hc, k < 2 ? 32'h0 : 32'hff, 32'hff);
      rdr_u.send(OP_CHECKED_READ);
      look(k < 2 ? 4'ha : 4'h0, mw(a[4:0]), '1);
      rdr_u.send(OP_READ);
      wok = 0;
      look(4'ha, mw(a[4:0]), '1);
      rd(ADDR_REPLY_HI);
      chk("reply_hi", mw(5'(a + 8'h4)), q);
      rd(ADDR_STATUS);
      chk("permit", {a, 1'b1}, {q[23:16], q[4]});
      wr(ADDR_SERIAL_HI, 32'h0);
      rdr_u.send(OP_READ);
      look(4'h0, 0, 0);
      rd(ADDR_STATUS);
      chk("permit", 0, q[4]);
      wr(ADDR_SERIAL_HI, SER[63:32]);
      wr(ADDR_ARGS, {16'h0, 8'(k), a});
      rdr_u.send(OP_VAR_FETCH);
      look(4'ha, mw(a[4:0]), 32'hff);
      for (int b = 0; b <= k + 1; b++) begin
        rd(ADDR_POP);
        chk("pop", b <= k ? mem[5'(a + b)] : 8'h00, q[7:0]);
      end
    end
    report_and_stop();
  end
endmodule : rtc_engine_tb
`default_nettype wire
